// ### hw/dbsm_map.vh
// Register map, field positions, reset values and gain constants of the
// DAC boost and sidetone mixer. Assumes inclusion by bare name only.
`ifndef DBSM_MAP_VH
`define DBSM_MAP_VH

// Register indices; byte address is four times the index
`define DBSM_IDX_POWER 6'h12
`define DBSM_IDX_AIF0 6'h18
`define DBSM_IDX_SIDE 6'h20
`define DBSM_IDX_STAT 6'h21
// Address bits that carry the register index
`define DBSM_AIDX_HI 7
`define DBSM_AIDX_LO 2

// Converter enable bits
`define DBSM_LEFT_ON_BIT 3
`define DBSM_RIGHT_ON_BIT 2
`define DBSM_ON_RST 1'h0
// Interface control fields
`define DBSM_BOOST_HI 10
`define DBSM_BOOST_LO 9
`define DBSM_BOOST_RST 2'h0
`define DBSM_LPICK_BIT 5
`define DBSM_RPICK_BIT 4
`define DBSM_LPICK_RST 1'h0
`define DBSM_RPICK_RST 1'h1
// Sidetone control fields
`define DBSM_LATT_HI 11
`define DBSM_LATT_LO 8
`define DBSM_RATT_HI 7
`define DBSM_RATT_LO 4
`define DBSM_LSRC_HI 3
`define DBSM_LSRC_LO 2
`define DBSM_RSRC_HI 1
`define DBSM_RSRC_LO 0
`define DBSM_ATT_RST 4'h0
`define DBSM_SRC_RST 2'h0
// Status bits
`define DBSM_ST_RATE_BIT 0
`define DBSM_ST_LSAT_BIT 1
`define DBSM_ST_RSAT_BIT 2
// Byte lanes
`define DBSM_LANE0 0
`define DBSM_LANE1 1

// Sidetone source codes
`define DBSM_SRC_NONE 2'h0
`define DBSM_SRC_LEFT 2'h1
`define DBSM_SRC_RIGHT 2'h2

// Bus responses
`define DBSM_RESP_OKAY 2'h0
`define DBSM_RESP_SLVERR 2'h2

// Sidetone gain coefficients, unsigned, unity is 16'h8000
`define DBSM_COEF_FRAC 15
`define DBSM_COEF_M36 16'h0207
`define DBSM_COEF_M33 16'h02de
`define DBSM_COEF_M30 16'h040c
`define DBSM_COEF_M27 16'h05b8
`define DBSM_COEF_M24 16'h0814
`define DBSM_COEF_M21 16'h0b68
`define DBSM_COEF_M18 16'h101d
`define DBSM_COEF_M15 16'h16c3
`define DBSM_COEF_M12 16'h2027
`define DBSM_COEF_M9 16'h2d6b
`define DBSM_COEF_M6 16'h4027
`define DBSM_COEF_M3 16'h5a9e
`define DBSM_COEF_0DB 16'h8000

// Saturation limits of a 24-bit sample
`define DBSM_SAT_MAX 24'h7fffff
`define DBSM_SAT_MIN 24'h800000

`endif

// ### hw/dbsm_chan.v
// One DAC channel: playback pick, boost, sidetone gain, saturating sum.
// Assumes all inputs come from logic on aclk; strobe marks a new sample.
`timescale 1ns/100ps
`include "dbsm_map.vh"

module dbsm_chan
#(
   parameter W = 24
)
(
   // Clock and reset
   input wire aclk,
   input wire aresetn,
   // Playback samples
   input wire strobe,
   input wire signed [W-1:0] play_l,
   input wire signed [W-1:0] play_r,
   // Controls
   input wire enable,
   input wire pick,
   input wire [1:0] boost,
   input wire [1:0] src,
   input wire [3:0] atten,
   input wire st_allow,
   // Sidetone samples from the ADC high-pass outputs
   input wire signed [W-1:0] adc_l,
   input wire signed [W-1:0] adc_r,
   // Mixed sample to the interpolation filter
   output reg signed [W-1:0] mix_r,
   output reg valid_r,
   output reg sat_r
);

   // Attenuation code to gain coefficient
   function [15:0] coef_of;
      input [3:0] code;
      begin
         case (code)
            4'h0: coef_of = `DBSM_COEF_M36;
            4'h1: coef_of = `DBSM_COEF_M33;
            4'h2: coef_of = `DBSM_COEF_M30;
            4'h3: coef_of = `DBSM_COEF_M27;
            4'h4: coef_of = `DBSM_COEF_M24;
            4'h5: coef_of = `DBSM_COEF_M21;
            4'h6: coef_of = `DBSM_COEF_M18;
            4'h7: coef_of = `DBSM_COEF_M15;
            4'h8: coef_of = `DBSM_COEF_M12;
            4'h9: coef_of = `DBSM_COEF_M9;
            4'ha: coef_of = `DBSM_COEF_M6;
            4'hb: coef_of = `DBSM_COEF_M3;
            default: coef_of = `DBSM_COEF_0DB;
         endcase
      end
   endfunction

   // Playback source pick
   wire signed [W-1:0] pick_s = pick ? play_r : play_l;
   wire signed [W+3:0] pick_x = {{4{pick_s[W-1]}}, pick_s}; // Headroom for boost and sum
   // Boost is a left shift of 0 to 3 bits
   wire signed [W+3:0] boosted = pick_x <<< boost;
   // Sidetone source and gain
   wire src_ok = (src == `DBSM_SRC_LEFT) || (src == `DBSM_SRC_RIGHT);
   wire st_on = st_allow && src_ok;
   wire signed [W-1:0] st_s = (src == `DBSM_SRC_RIGHT) ? adc_r : adc_l;
   wire signed [16:0] coef_s = {1'b0, coef_of(atten)};
   wire signed [W+16:0] prod = st_s * coef_s; // Product of sample and gain
   wire signed [W+16:0] prod_sh = prod >>> `DBSM_COEF_FRAC; // Back to sample scale
   wire signed [W+3:0] st_val = st_on ? prod_sh[W+3:0] : {(W+4){1'b0}};
   // Playback plus sidetone
   wire signed [W+3:0] sum = boosted + st_val;
   wire signed [W+3:0] lim_hi = {{4{1'b0}}, `DBSM_SAT_MAX};
   wire signed [W+3:0] lim_lo = {{4{1'b1}}, `DBSM_SAT_MIN};
   wire over = sum > lim_hi;
   wire under = sum < lim_lo;

   // Output register, loaded once per sample strobe
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         mix_r <= {W{1'b0}};
         valid_r <= 1'b0;
         sat_r <= 1'b0;
      end
      else if (strobe && enable)
      begin
         // Saturate rather than wrap
         if (over)
            mix_r <= `DBSM_SAT_MAX;
         else if (under)
            mix_r <= `DBSM_SAT_MIN;
         else
            mix_r <= sum[W-1:0];
         valid_r <= 1'b1;
         sat_r <= over || under;
      end
      else
      begin
         // Disabled converter sees silence
         if (!enable)
            mix_r <= {W{1'b0}};
         valid_r <= 1'b0;
         sat_r <= 1'b0;
      end
   end

endmodule

// ### hw/dbsm_top.v
// Top of the DAC boost and sidetone mixer with its AXI4-Lite registers.
// Assumes playback, ADC and rate-match inputs are logic on aclk; the
// interpolation filters take the 24-bit mixed samples and valid pulses.
//
// The AXI4-Lite register port was left to the implementer.
`timescale 1ns/100ps
`include "dbsm_map.vh"

// Summary of operation
// - Boost playback by 0, 6, 12, 18 dB
// - Sidetone only when sample rates match
// - Either ADC summed into each DAC
// - Sidetone taken after ADC high-pass
// - Left sidetone source in bits 3:2
// - Right sidetone source in bits 1:0
// - Left sidetone attenuation in bits 11:8
// - Right sidetone attenuation in bits 7:4
// - Minus 36 dB up in 3 dB steps
// - DAC input is playback plus sidetone
// - Mixed 24-bit samples feed interpolation filters
// - DAC enables in power bits 3, 2
// - Each DAC picks left or right channel
module dbsm_top
#(
   parameter W = 24,
   parameter ADDR_W = 8
)
(
   // Clock and reset
   input wire aclk,
   input wire aresetn,
   // AXI4-Lite write address
   input wire [ADDR_W-1:0] s_axi_awaddr,
   input wire [2:0] s_axi_awprot,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   // AXI4-Lite write data
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   // AXI4-Lite write response
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   // AXI4-Lite read address
   input wire [ADDR_W-1:0] s_axi_araddr,
   input wire [2:0] s_axi_arprot,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   // AXI4-Lite read data
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   // Playback samples from the audio interface
   input wire play_valid,
   input wire signed [W-1:0] play_l_in,
   input wire signed [W-1:0] play_r_in,
   // ADC high-pass filter outputs
   input wire adc_valid,
   input wire signed [W-1:0] adc_hpf_l,
   input wire signed [W-1:0] adc_hpf_r,
   // ADC and DAC run at one sample rate
   input wire rates_equal,
   // Mixed samples to the interpolation filters
   output wire signed [W-1:0] dac_l_data,
   output wire dac_l_valid,
   output wire signed [W-1:0] dac_r_data,
   output wire dac_r_valid,
   // Converter enables
   output reg left_converter_on,
   output reg right_converter_on
);

   // True when an index names a mapped register
   function is_mapped;
      input [5:0] idx;
      begin
         case (idx)
            `DBSM_IDX_POWER: is_mapped = 1'b1;
            `DBSM_IDX_AIF0: is_mapped = 1'b1;
            `DBSM_IDX_SIDE: is_mapped = 1'b1;
            `DBSM_IDX_STAT: is_mapped = 1'b1;
            default: is_mapped = 1'b0;
         endcase
      end
   endfunction

   // Control fields
   reg [1:0] boost_r; // Playback boost code
   reg left_pick_r; // Left DAC playback channel
   reg right_pick_r; // Right DAC playback channel
   reg [3:0] left_att_r; // Left sidetone attenuation
   reg [3:0] right_att_r; // Right sidetone attenuation
   reg [1:0] left_src_r; // Left DAC sidetone source
   reg [1:0] right_src_r; // Right DAC sidetone source
   // Status
   reg rate_r; // Registered rate match
   reg lsat_r; // Left sum saturated, sticky
   reg rsat_r; // Right sum saturated, sticky
   // Held ADC samples
   reg signed [W-1:0] adc_l_r;
   reg signed [W-1:0] adc_r_r;
   // Write channel state
   reg [ADDR_W-1:0] aw_addr_r; // Captured write address
   reg aw_full_r; // Write address held
   reg [31:0] w_data_r; // Captured write data
   reg [3:0] w_strb_r; // Captured byte strobes
   reg w_full_r; // Write data held
   // Read mux value
   reg [31:0] rd_word;

   // Handshake terms
   wire aw_take = s_axi_awvalid && s_axi_awready;
   wire w_take = s_axi_wvalid && s_axi_wready;
   wire ar_take = s_axi_arvalid && s_axi_arready;
   wire wr_fire = aw_full_r && w_full_r && !s_axi_bvalid;
   wire [5:0] wr_idx = aw_addr_r[`DBSM_AIDX_HI:`DBSM_AIDX_LO];
   wire [5:0] rd_idx = s_axi_araddr[`DBSM_AIDX_HI:`DBSM_AIDX_LO];
   wire lane0 = w_strb_r[`DBSM_LANE0];
   wire lane1 = w_strb_r[`DBSM_LANE1];
   // Saturation pulses from the channels
   wire lsat_set;
   wire rsat_set;
   // Status clear strobes
   wire stat_wr = wr_fire && (wr_idx == `DBSM_IDX_STAT) && lane0;
   wire lsat_clr = stat_wr && w_data_r[`DBSM_ST_LSAT_BIT];
   wire rsat_clr = stat_wr && w_data_r[`DBSM_ST_RSAT_BIT];

   // Write address and data capture, then response
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `DBSM_RESP_OKAY;
         aw_full_r <= 1'b0;
         w_full_r <= 1'b0;
         aw_addr_r <= {ADDR_W{1'b0}};
         w_data_r <= 32'h0;
         w_strb_r <= 4'h0;
      end
      else
      begin
         // Address taken in either order against data
         if (aw_take)
         begin
            aw_addr_r <= s_axi_awaddr;
            aw_full_r <= 1'b1;
            s_axi_awready <= 1'b0;
         end
         else if (!aw_full_r && !s_axi_bvalid)
            s_axi_awready <= 1'b1;
         // Data taken
         if (w_take)
         begin
            w_data_r <= s_axi_wdata;
            w_strb_r <= s_axi_wstrb;
            w_full_r <= 1'b1;
            s_axi_wready <= 1'b0;
         end
         else if (!w_full_r && !s_axi_bvalid)
            s_axi_wready <= 1'b1;
         // Both halves held: write and answer
         if (wr_fire)
         begin
            aw_full_r <= 1'b0;
            w_full_r <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= is_mapped(wr_idx) ? `DBSM_RESP_OKAY : `DBSM_RESP_SLVERR;
         end
         else if (s_axi_bvalid && s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end
   end

   // Control registers, written lane by lane
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         left_converter_on <= `DBSM_ON_RST;
         right_converter_on <= `DBSM_ON_RST;
         boost_r <= `DBSM_BOOST_RST;
         left_pick_r <= `DBSM_LPICK_RST;
         right_pick_r <= `DBSM_RPICK_RST;
         left_att_r <= `DBSM_ATT_RST;
         right_att_r <= `DBSM_ATT_RST;
         left_src_r <= `DBSM_SRC_RST;
         right_src_r <= `DBSM_SRC_RST;
      end
      else if (wr_fire)
      begin
         case (wr_idx)
            `DBSM_IDX_POWER:
            begin
               // Converter enables
               if (lane0)
               begin
                  left_converter_on <= w_data_r[`DBSM_LEFT_ON_BIT];
                  right_converter_on <= w_data_r[`DBSM_RIGHT_ON_BIT];
               end
            end
            `DBSM_IDX_AIF0:
            begin
               // Boost and playback picks
               if (lane1)
                  boost_r <= w_data_r[`DBSM_BOOST_HI:`DBSM_BOOST_LO];
               if (lane0)
               begin
                  left_pick_r <= w_data_r[`DBSM_LPICK_BIT];
                  right_pick_r <= w_data_r[`DBSM_RPICK_BIT];
               end
            end
            `DBSM_IDX_SIDE:
            begin
               // Sidetone gains and sources
               if (lane1)
                  left_att_r <= w_data_r[`DBSM_LATT_HI:`DBSM_LATT_LO];
               if (lane0)
               begin
                  right_att_r <= w_data_r[`DBSM_RATT_HI:`DBSM_RATT_LO];
                  left_src_r <= w_data_r[`DBSM_LSRC_HI:`DBSM_LSRC_LO];
                  right_src_r <= w_data_r[`DBSM_RSRC_HI:`DBSM_RSRC_LO];
               end
            end
            // Status and unmapped words hold no control
            default: boost_r <= boost_r;
         endcase
      end
   end

   // Status: a new saturation wins over a clear in the same cycle
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         rate_r <= 1'b0;
         lsat_r <= 1'b0;
         rsat_r <= 1'b0;
      end
      else
      begin
         rate_r <= rates_equal;
         lsat_r <= (lsat_r && !lsat_clr) || lsat_set;
         rsat_r <= (rsat_r && !rsat_clr) || rsat_set;
      end
   end

   // Read mux; reserved bits read zero
   always @*
   begin
      rd_word = 32'h0;
      case (rd_idx)
         `DBSM_IDX_POWER:
         begin
            rd_word[`DBSM_LEFT_ON_BIT] = left_converter_on;
            rd_word[`DBSM_RIGHT_ON_BIT] = right_converter_on;
         end
         `DBSM_IDX_AIF0:
         begin
            rd_word[`DBSM_BOOST_HI:`DBSM_BOOST_LO] = boost_r;
            rd_word[`DBSM_LPICK_BIT] = left_pick_r;
            rd_word[`DBSM_RPICK_BIT] = right_pick_r;
         end
         `DBSM_IDX_SIDE:
         begin
            rd_word[`DBSM_LATT_HI:`DBSM_LATT_LO] = left_att_r;
            rd_word[`DBSM_RATT_HI:`DBSM_RATT_LO] = right_att_r;
            rd_word[`DBSM_LSRC_HI:`DBSM_LSRC_LO] = left_src_r;
            rd_word[`DBSM_RSRC_HI:`DBSM_RSRC_LO] = right_src_r;
         end
         `DBSM_IDX_STAT:
         begin
            rd_word[`DBSM_ST_RATE_BIT] = rate_r;
            rd_word[`DBSM_ST_LSAT_BIT] = lsat_r;
            rd_word[`DBSM_ST_RSAT_BIT] = rsat_r;
         end
         default: rd_word = 32'h0;
      endcase
   end

   // Read channel: one read at a time, data one cycle after address
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0;
         s_axi_rresp <= `DBSM_RESP_OKAY;
      end
      else if (ar_take)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_word;
         s_axi_rresp <= is_mapped(rd_idx) ? `DBSM_RESP_OKAY : `DBSM_RESP_SLVERR;
      end
      else if (s_axi_rvalid && s_axi_rready)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b1;
      end
      else if (!s_axi_rvalid)
         s_axi_arready <= 1'b1;
   end

   // Hold the latest high-pass filtered ADC samples for sidetone
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         adc_l_r <= {W{1'b0}};
         adc_r_r <= {W{1'b0}};
      end
      else if (adc_valid)
      begin
         adc_l_r <= adc_hpf_l;
         adc_r_r <= adc_hpf_r;
      end
   end

   // Left DAC channel
   dbsm_chan #(.W(W)) u_left
   (
      .aclk(aclk), .aresetn(aresetn),
      .strobe(play_valid),
      .play_l(play_l_in), .play_r(play_r_in),
      .enable(left_converter_on),
      .pick(left_pick_r),
      .boost(boost_r),
      .src(left_src_r), .atten(left_att_r),
      .st_allow(rate_r),
      .adc_l(adc_l_r), .adc_r(adc_r_r),
      .mix_r(dac_l_data), .valid_r(dac_l_valid),
      .sat_r(lsat_set)
   );

   // Right DAC channel
   dbsm_chan #(.W(W)) u_right
   (
      .aclk(aclk), .aresetn(aresetn),
      .strobe(play_valid),
      .play_l(play_l_in), .play_r(play_r_in),
      .enable(right_converter_on),
      .pick(right_pick_r),
      .boost(boost_r),
      .src(right_src_r), .atten(right_att_r),
      .st_allow(rate_r),
      .adc_l(adc_l_r), .adc_r(adc_r_r),
      .mix_r(dac_r_data), .valid_r(dac_r_valid),
      .sat_r(rsat_set)
   );

endmodule

// ### tb/dbsm_top_properties.sv
// Port-level assertions for the DAC boost and sidetone mixer top.
// Assumes binding onto dbsm_top, all signals on aclk.
`timescale 1ns/100ps
module dbsm_top_properties
(
   // Clock and reset
   input wire aclk,
   input wire aresetn,
   // Bus handshakes
   input wire s_axi_awvalid,
   input wire s_axi_awready,
   input wire s_axi_bvalid,
   input wire s_axi_bready,
   input wire s_axi_arvalid,
   input wire s_axi_arready,
   input wire s_axi_rvalid,
   input wire s_axi_rready,
   input wire [31:0] s_axi_rdata,
   // Sample stream
   input wire play_valid,
   input wire dac_l_valid,
   input wire dac_r_valid,
   // Converter enables
   input wire left_converter_on,
   input wire right_converter_on
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   // Enabled channel answers a sample one cycle later
   a_left_sample_out: assert property (play_valid && left_converter_on |=> dac_l_valid)
      else $error("left sample not passed on");
   // Disabled channel stays silent
   a_right_off_quiet: assert property (!right_converter_on && !$past(right_converter_on)
      |-> !dac_r_valid)
      else $error("right valid while off");
   // Every left output sample has a playback cause
   a_left_valid_cause: assert property (dac_l_valid |-> $past(play_valid))
      else $error("left valid without sample");
   // Output valid is a single pulse
   a_right_pulse_len: assert property (dac_r_valid && !play_valid |=> !dac_r_valid)
      else $error("right valid too long");
   // Reset leaves both converters off
   a_reset_conv_off: assert property (disable iff (1'b0)
      !aresetn |=> !left_converter_on && !right_converter_on)
      else $error("converter on after reset");
   // Read answer and hold
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   a_read_data_hold: assert property (s_axi_rvalid && !s_axi_rready
      |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped");
   // Write response holds and address is refused while busy
   a_write_resp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write response dropped");
   a_write_refused: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
      else $error("second write address accepted");
endmodule

bind dbsm_top dbsm_top_properties u_props
(
   .aclk(aclk), .aresetn(aresetn),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
   .play_valid(play_valid), .dac_l_valid(dac_l_valid), .dac_r_valid(dac_r_valid),
   .left_converter_on(left_converter_on), .right_converter_on(right_converter_on)
);

// ### tb/dbsm_host_feed.sv
// Host side playback source: one sample pair per send request.
// Assumes send is a one-cycle request on aclk.
`timescale 1ns/100ps
module dbsm_host_feed
(
   // Clock and request
   input wire aclk,
   input wire send,
   input wire [23:0] l,
   input wire [23:0] r,
   // Playback stream
   output reg play_valid = 1'b0,
   output reg [23:0] play_l = 24'h000000,
   output reg [23:0] play_r = 24'h000000
);
   // Data valid only with its strobe; otherwise lines toggle
   always @(posedge aclk)
   begin
      play_valid <= send;
      if (send)
      begin
         play_l <= l;
         play_r <= r;
      end
      else
      begin
         play_l <= ~play_l;
         play_r <= ~play_r;
      end
   end
endmodule

// ### tb/dbsm_top_tb.sv
// Self-checking bench of the DAC boost and sidetone mixer.
// Assumes dbsm_top, the host feed model and the bound checker.
`timescale 1ns/100ps
`include "dbsm_map.vh"
module dbsm_top_tb;
   // Bench signals
   logic aclk = 0, aresetn = 0, send = 0, adc_valid = 0, rates_equal = 1;
   logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic [7:0] awaddr = 0, araddr = 0;
   logic [31:0] wdata = 0, d;
   logic [23:0] sl = 0, sr = 0, adc_l = 0, adc_r = 0, e;
   logic [1:0] rs;
   wire awready, wready, bvalid, arready, rvalid, pv, lv, rv, lon, ron;
   wire [1:0] bresp, rresp;
   wire [31:0] rdata;
   wire [23:0] pl, pr, dl, dr;
   int failures = 0, num_checks = 0, cycles = 0;

   always #50 aclk = ~aclk;

   dbsm_host_feed u_dbsm_host_feed (.aclk(aclk), .send(send), .l(sl), .r(sr),
      .play_valid(pv), .play_l(pl), .play_r(pr));
   dbsm_top u_dbsm_top (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .play_valid(pv), .play_l_in(pl), .play_r_in(pr),
      .adc_valid(adc_valid), .adc_hpf_l(adc_l), .adc_hpf_r(adc_r),
      .rates_equal(rates_equal), .dac_l_data(dl), .dac_l_valid(lv),
      .dac_r_data(dr), .dac_r_valid(rv), .left_converter_on(lon),
      .right_converter_on(ron));

   // Verdict and end of run
   task complete_run;
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // Hang guard
   always @(posedge aclk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         failures++;
         complete_run();
      end
   end

   task chk(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         failures++;
         $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Bus write; handshakes judged at the falling edge, released after rising;
   // the response is taken a cycle late so that its hold is exercised
   task axw(input logic [7:0] a, input logic [31:0] v);
      bit aw, w, b, bv;
      b = 0;
      @(posedge aclk);
      awaddr <= a;
      wdata <= v;
      awvalid <= 1;
      wvalid <= 1;
      while (!b)
      begin
         @(negedge aclk);
         aw = awvalid && awready;
         w = wvalid && wready;
         b = bvalid && bready;
         bv = bvalid;
         @(posedge aclk);
         if (aw) awvalid <= 0;
         if (w) wvalid <= 0;
         if (b) bready <= 0;
         else if (bv) bready <= 1;
      end
   endtask

   // Bus read returning data and response; data taken a cycle late
   task axr(input logic [7:0] a);
      bit ar, r, rv;
      r = 0;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1;
      while (!r)
      begin
         @(negedge aclk);
         ar = arvalid && arready;
         r = rvalid && rready;
         rv = rvalid;
         d = rdata;
         rs = rresp;
         @(posedge aclk);
         if (ar) arvalid <= 0;
         if (r) rready <= 0;
         else if (rv) rready <= 1;
      end
   endtask

   // Gain of a sidetone coefficient in Q15
   function logic [23:0] att(input logic signed [23:0] a, input logic [15:0] c);
      logic signed [47:0] p;
      p = a * $signed({1'b0, c});
      att = p >>> 15;
   endfunction

   // One sample pair through the mixer, then compare both outputs
   task mix(input logic [23:0] l, r, el, er);
      @(posedge aclk);
      sl <= l;
      sr <= r;
      send <= 1;
      @(posedge aclk);
      send <= 0;
      @(posedge aclk);
      #1;
      chk({8'h00, dl}, {8'h00, el});
      chk({8'h00, dr}, {8'h00, er});
   endtask

   task t_regs;
      axr(8'h48); chk(d, 32'h0);
      axr(8'h60); chk(d, 32'h10);
      axr(8'h80); chk(d, 32'h0);
      axr(8'h04); chk({d[31:2], rs}, {30'h0, `DBSM_RESP_SLVERR});
      axw(8'h80, 32'h0fff);
      axr(8'h80); chk(d, 32'hfff);
   endtask

   // Playback kept below the boost headroom
   task t_boost;
      axw(8'h48, 32'hc);
      axw(8'h80, 32'h0);
      for (int b = 0; b < 4; b++)
      begin
         axw(8'h60, (b << 9) | 32'h10);
         mix(24'h001234, 24'hffff00, 24'h001234 << b, 24'hffff00 << b);
      end
      axw(8'h60, 32'h20);
      mix(24'h000111, 24'h000222, 24'h000222, 24'h000111);
      axw(8'h60, 32'h10);
   endtask

   task t_side;
      @(posedge aclk);
      adc_l <= 24'h000400;
      adc_r <= 24'hfff800;
      // One ADC sample pair is held before sidetone reaches the converters
      adc_valid <= 1;
      @(posedge aclk);
      adc_valid <= 0;
      for (int s = 0; s < 4; s++)
      begin
         axw(8'h80, 32'hcc0 | (s << 2) | s);
         e = (s == 1) ? 24'h000400 : (s == 2) ? 24'hfff800 : 24'h0;
         mix(24'h10, 24'h10, 24'h10 + e, 24'h10 + e);
      end
      axw(8'h80, 32'hb06);
      mix(24'h10, 24'h10, 24'h10 + att(24'h000400, `DBSM_COEF_M3),
         24'h10 + att(24'hfff800, `DBSM_COEF_M36));
      axw(8'h80, 32'hcc5);
      mix(24'h7ffff0, 24'h0, 24'h7fffff, 24'h000400);
      @(posedge aclk);
      rates_equal <= 0;
      repeat (3) @(posedge aclk);
      mix(24'h10, 24'h10, 24'h10, 24'h10);
      @(posedge aclk);
      rates_equal <= 1;
   endtask

   // Deliberately past the headroom to reach the clip limits
   task t_sat;
      axw(8'h80, 32'h0);
      axw(8'h60, 32'h610);
      mix(24'h200000, 24'he00000, 24'h7fffff, 24'h800000);
      // Status: rates match, both sums clipped; write one clears the clip flags
      axr(8'h84);
      chk(d, 32'h7);
      axw(8'h84, 32'h6);
      axr(8'h84);
      chk(d, 32'h1);
   endtask

   task t_off;
      axw(8'h48, 32'h8);
      mix(24'h1, 24'h1, 24'h8, 24'h0);
      chk({31'h0, lv}, 32'h1);
      chk({31'h0, rv}, 32'h0);
   endtask

   initial
   begin
      repeat (6) @(posedge aclk);
      aresetn <= 1;
      t_regs();
      t_boost();
      t_side();
      t_sat();
      t_off();
      complete_run();
   end
endmodule
